// file: rtl/ohp_host_port.sv
// Function
// - while reset input is low, the controller initialises and stays idle.
// - transfers are accepted only while chip select is low.
// - data/command high routes the parallel byte as display data.
// - data/command low routes the parallel byte to the command register.
// - four-wire serial words route to data or command by the same select; three-wire words route by their first bit.
// - device drives a frame status output showing driver state.
`timescale 1ns/100ps
`default_nettype none

module ohp_host_port
    import ohp_pkg::*;
#(
    parameter int unsigned FRAME_HALF_CYCLES = FRAME_HALF_CYCLES_DEF
)(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_reset_in_n,
    input wire logic i_cs_n,
    input wire logic i_dc_sel,
    input wire logic i_wr_n,
    input wire logic i_protocol_sel_0,
    input wire logic i_protocol_sel_1,
    input wire logic [7:0] i_host_data_bus,
    output logic [7:0] o_host_data_bus,
    output logic o_host_data_bus_oe,
    output logic o_frame_status_out,
    output logic o_init_active,
    output logic o_host_busy,
    output logic o_overrun,
    output logic o_byte_valid,
    input wire logic i_byte_ready,
    output logic [7:0] o_byte_data,
    output logic o_byte_is_data
);

    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] meta_reg;
    logic [PIN_W-1:0] s;

    ohp_state_e state_reg, state_next;
    logic [7:0] init_cnt_reg, init_cnt_next;
    logic [1:0] proto_reg, proto_next;
    logic [7:0] shift_reg, shift_next;
    logic [3:0] bit_cnt_reg, bit_cnt_next;
    logic pend_valid_reg, pend_valid_next;
    logic [7:0] pend_byte_reg, pend_byte_next;
    logic pend_dc_reg, pend_dc_next;
    logic overrun_reg, overrun_next;
    logic [FRAME_CNT_W-1:0] frame_cnt_reg, frame_cnt_next;
    logic frame_reg, frame_next;
    logic wr_n_d_reg, wr_n_d_next;
    logic sclk_d_reg, sclk_d_next;
    logic cap_valid;
    logic [7:0] cap_byte;
    logic cap_dc;
    logic fifo_in_ready;
    logic fifo_flush;
    logic [FIFO_WIDTH-1:0] fifo_out_data;

    // =============================================================
    // pin synchronisers
    assign pins_raw = {i_reset_in_n, i_cs_n, i_dc_sel, i_wr_n,
                       i_protocol_sel_1, i_protocol_sel_0, i_host_data_bus};

    for (genvar g = 0; g < PIN_W; g++)
    begin : g_sync
        always_ff @(posedge i_ref_clk)
        begin
            if (i_srst)
            begin
                meta_reg[g] <= SYNC_RST_VAL[g];
                s[g] <= SYNC_RST_VAL[g];
            end
            else
            begin
                meta_reg[g] <= pins_raw[g];
                s[g] <= meta_reg[g];
            end
        end
    end

    // =============================================================
    // capture and sequencing
    always_comb
    begin
        state_next = state_reg;
        init_cnt_next = init_cnt_reg;
        proto_next = proto_reg;
        shift_next = shift_reg;
        bit_cnt_next = bit_cnt_reg;
        pend_valid_next = pend_valid_reg;
        pend_byte_next = pend_byte_reg;
        pend_dc_next = pend_dc_reg;
        overrun_next = 1'b0;
        frame_cnt_next = frame_cnt_reg;
        frame_next = frame_reg;
        wr_n_d_next = s[PIN_WR_N];
        sclk_d_next = s[PIN_SCLK];
        cap_valid = 1'b0;
        cap_byte = '0;
        cap_dc = 1'b0;
        if (pend_valid_reg && fifo_in_ready)
        begin
            pend_valid_next = 1'b0;
        end
        case (state_reg)
            ST_INIT:
            begin
                proto_next = {s[PIN_PSEL1], s[PIN_PSEL0]};
                shift_next = '0;
                bit_cnt_next = '0;
                pend_valid_next = 1'b0;
                frame_cnt_next = '0;
                frame_next = 1'b0;
                if (!s[PIN_RST_N])
                begin
                    init_cnt_next = INIT_CYCLES;
                end
                else if (init_cnt_reg == '0)
                begin
                    state_next = ST_RUN;
                end
                else
                begin
                    init_cnt_next = init_cnt_reg - 1'b1;
                end
            end
            ST_RUN:
            begin
                if (frame_cnt_reg == FRAME_CNT_W'(FRAME_HALF_CYCLES - 1))
                begin
                    frame_cnt_next = '0;
                    frame_next = !frame_reg;
                end
                else
                begin
                    frame_cnt_next = frame_cnt_reg + 1'b1;
                end
                if (!s[PIN_RST_N])
                begin
                    state_next = ST_INIT;
                    init_cnt_next = INIT_CYCLES;
                    // frame status reads low from the first init cycle
                    frame_cnt_next = '0;
                    frame_next = 1'b0;
                end
                else if (s[PIN_CS_N])
                begin
                    bit_cnt_next = '0;
                end
                else if (proto_reg[1])
                begin
                    if (!wr_n_d_reg && s[PIN_WR_N])
                    begin
                        cap_valid = 1'b1;
                        cap_byte = s[PIN_DATA_LSB +: BYTE_W];
                        cap_dc = s[PIN_DC];
                    end
                end
                else if (!sclk_d_reg && s[PIN_SCLK])
                begin
                    // shift line one on line zero rising
                    shift_next = {shift_reg[6:0], s[PIN_SERIAL_DATA_IN]};
                    bit_cnt_next = bit_cnt_reg + 1'b1;
                    if (proto_reg == PROTO_SER3 && bit_cnt_reg == SPI_LAST_3W)
                    begin
                        // select pin unused, first bit carries the route
                        cap_valid = 1'b1;
                        cap_byte = {shift_reg[6:0], s[PIN_SERIAL_DATA_IN]};
                        cap_dc = shift_reg[7];
                        bit_cnt_next = '0;
                    end
                    else if (proto_reg == PROTO_SER4 && bit_cnt_reg == SPI_LAST_4W)
                    begin
                        cap_valid = 1'b1;
                        cap_byte = {shift_reg[6:0], s[PIN_SERIAL_DATA_IN]};
                        cap_dc = s[PIN_DC];
                        bit_cnt_next = '0;
                    end
                end
            end
            default:
            begin
                state_next = ST_INIT;
                init_cnt_next = INIT_CYCLES;
            end
        endcase
        // one holding slot: a byte that finds it still full is lost and flagged
        if (cap_valid)
        begin
            if (pend_valid_next)
            begin
                overrun_next = 1'b1;
            end
            else
            begin
                pend_valid_next = 1'b1;
                pend_byte_next = cap_byte;
                pend_dc_next = cap_dc;
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            state_reg <= ST_INIT;
            init_cnt_reg <= INIT_CYCLES;
            proto_reg <= PROTO_PAR;
            shift_reg <= '0;
            bit_cnt_reg <= '0;
            pend_valid_reg <= 1'b0;
            pend_byte_reg <= '0;
            pend_dc_reg <= 1'b0;
            overrun_reg <= 1'b0;
            frame_cnt_reg <= '0;
            frame_reg <= 1'b0;
            wr_n_d_reg <= 1'b1;
            sclk_d_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            init_cnt_reg <= init_cnt_next;
            proto_reg <= proto_next;
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
            pend_valid_reg <= pend_valid_next;
            pend_byte_reg <= pend_byte_next;
            pend_dc_reg <= pend_dc_next;
            overrun_reg <= overrun_next;
            frame_cnt_reg <= frame_cnt_next;
            frame_reg <= frame_next;
            wr_n_d_reg <= wr_n_d_next;
            sclk_d_reg <= sclk_d_next;
        end
    end

    // =============================================================
    // byte buffer and outputs
    // initialisation also empties the buffer
    assign fifo_flush = i_srst || (state_reg == ST_INIT);

    ohp_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_srst(fifo_flush),
        .i_in_valid(pend_valid_reg),
        .o_in_ready(fifo_in_ready),
        .i_in_data({pend_dc_reg, pend_byte_reg}),
        .o_out_valid(o_byte_valid),
        .i_out_ready(i_byte_ready),
        .o_out_data(fifo_out_data)
    );

    assign o_byte_data = fifo_out_data[BYTE_W-1:0];
    assign o_byte_is_data = fifo_out_data[BYTE_W];
    // reads are not served by this block, so the bus is never driven
    assign o_host_data_bus = '0;
    assign o_host_data_bus_oe = 1'b0;
    assign o_frame_status_out = frame_reg;
    assign o_init_active = (state_reg == ST_INIT);
    assign o_host_busy = pend_valid_reg;
    assign o_overrun = overrun_reg;

endmodule // ohp_host_port

`default_nettype wire

// file: rtl/ohp_pkg.sv
`default_nettype none

// =============================================================
// constants of the host port
package ohp_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int INIT_TIME_NS = 1000;
    localparam int INIT_CYCLES_INT = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] INIT_CYCLES = 8'(INIT_CYCLES_INT);
    localparam int FRAME_PERIOD_US = 10000;
    localparam int FRAME_HALF_CYCLES_DEF = (FRAME_PERIOD_US * 1000) / CLK_PERIOD_NS / 2;
    localparam int FRAME_CNT_W = 20;

    // synchronised pin vector layout
    localparam int PIN_W = 14;
    localparam int PIN_DATA_LSB = 0;
    localparam int PIN_SCLK = 0;
    localparam int PIN_SERIAL_DATA_IN = 1;
    localparam int PIN_PSEL0 = 8;
    localparam int PIN_PSEL1 = 9;
    localparam int PIN_WR_N = 10;
    localparam int PIN_DC = 11;
    localparam int PIN_CS_N = 12;
    localparam int PIN_RST_N = 13;
    localparam logic [PIN_W-1:0] SYNC_RST_VAL = 14'h1400;

    // protocol select codes {protocol_sel_1, protocol_sel_0}; 2'h3 acts as parallel
    localparam logic [1:0] PROTO_SER4 = 2'h0;
    localparam logic [1:0] PROTO_SER3 = 2'h1;
    localparam logic [1:0] PROTO_PAR = 2'h2;

    // serial framing: index of the last bit of a word
    localparam logic [3:0] SPI_LAST_4W = 4'h7;
    localparam logic [3:0] SPI_LAST_3W = 4'h8;

    // byte stream buffer
    localparam int BYTE_W = 8;
    localparam int FIFO_WIDTH = 9;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [0:0] {
        ST_INIT = 1'b0,
        ST_RUN = 1'b1
    } ohp_state_e;

endpackage

`default_nettype wire

// file: rtl/ohp_fifo.sv
`timescale 1ns/100ps
`default_nettype none

// =============================================================
// first-in first-out buffer with registered read data
module ohp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
)(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr_reg, wptr_next;
    logic [AW-1:0] rptr_reg, rptr_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic [WIDTH-1:0] out_reg, out_next;
    logic out_valid_reg, out_valid_next;
    logic push;
    logic pop;

    assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign o_out_valid = out_valid_reg;
    assign o_out_data = out_reg;

    // =============================================================
    // pointers and output stage
    always_comb
    begin
        push = i_in_valid && o_in_ready;
        pop = (cnt_reg != '0) && (!out_valid_reg || i_out_ready);
        wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
        rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
        cnt_next = cnt_reg;
        if (push && !pop)
        begin
            cnt_next = cnt_reg + 1'b1;
        end
        else if (pop && !push)
        begin
            cnt_next = cnt_reg - 1'b1;
        end
        out_next = out_reg;
        out_valid_next = out_valid_reg;
        if (pop)
        begin
            out_next = mem[rptr_reg];
            out_valid_next = 1'b1;
        end
        else if (i_out_ready)
        begin
            out_valid_next = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (push)
        begin
            mem[wptr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            cnt_reg <= '0;
            out_reg <= '0;
            out_valid_reg <= 1'b0;
        end
        else
        begin
            wptr_reg <= wptr_next;
            rptr_reg <= rptr_next;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
            out_valid_reg <= out_valid_next;
        end
    end

endmodule // ohp_fifo

`default_nettype wire

// file: tb/ohp_host_port_assertions.sv
`timescale 1ns/100ps
`default_nettype none

module ohp_chk #(
    parameter int unsigned FRAME_HALF_CYCLES = 8
)(
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire logic i_reset_in_n,
    input wire logic i_cs_n,
    input wire logic i_byte_ready,
    input wire logic o_frame_status_out,
    input wire logic o_init_active,
    input wire logic o_host_busy,
    input wire logic o_overrun,
    input wire logic o_byte_valid,
    input wire logic [7:0] o_byte_data,
    input wire logic o_byte_is_data
);
    logic prev_reg;
    logic seen_reg;
    logic [19:0] cnt_reg;
    logic chg;

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);

    // ==========================================
    // frame half period counter
    // seen gates the count until one edge in run has zeroed it
    assign chg = o_frame_status_out != prev_reg;
    always_ff @(posedge i_ref_clk)
    begin
        prev_reg <= o_frame_status_out;
        cnt_reg <= chg ? 20'h0 : cnt_reg + 20'h1;
        seen_reg <= !i_srst && !o_init_active && (seen_reg || chg);
    end

    // ==========================================
    // properties
    sequence s_pin_high;
        i_reset_in_n [*4];
    endsequence
    sequence s_stall;
        o_byte_valid && !i_byte_ready;
    endsequence

    a_pin_low_init: assert property ((!i_reset_in_n) [*4] |-> o_init_active)
        else $error("init not held while reset pin low");
    a_init_frame_low: assert property (o_init_active |-> !o_frame_status_out)
        else $error("frame status not low in init");
    a_take_needs_cs: assert property ($rose(o_host_busy) |->
        !$past(i_cs_n, 3) && !$past(i_cs_n, 4))
        else $error("byte taken without chip select");
    a_stall_holds: assert property (s_pin_high ##0 s_stall |=> o_byte_valid
        && $stable(o_byte_data) && $stable(o_byte_is_data))
        else $error("byte changed while stalled");
    a_byte_latency: assert property ($rose(o_host_busy) && !o_byte_valid
        |-> ##[1:3] o_byte_valid)
        else $error("byte late at output");
    // the forced clear on entry to init is not a half period
    a_frame_period: assert property (chg && seen_reg && !o_init_active
        |-> cnt_reg == FRAME_HALF_CYCLES - 1)
        else $error("frame half period wrong");
    a_frame_bound: assert property (seen_reg |-> cnt_reg < FRAME_HALF_CYCLES)
        else $error("frame status stuck");
    a_overrun_pulse: assert property (o_overrun |-> $past(o_host_busy) ##1 !o_overrun)
        else $error("bad overrun pulse");
endmodule // ohp_chk

bind ohp_host_port ohp_chk #(.FRAME_HALF_CYCLES(FRAME_HALF_CYCLES)) ohp_chk_i (
    .i_ref_clk, .i_srst, .i_reset_in_n, .i_cs_n, .i_byte_ready,
    .o_frame_status_out, .o_init_active, .o_host_busy, .o_overrun,
    .o_byte_valid, .o_byte_data, .o_byte_is_data
);

`default_nettype wire

// file: tb/ohp_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module ohp_host_model (
    input wire logic i_ref_clk,
    output logic o_reset_in_n,
    output logic o_cs_n,
    output logic o_dc_sel,
    output logic o_wr_n,
    output logic o_protocol_sel_0,
    output logic o_protocol_sel_1,
    output logic [7:0] o_host_data_bus
);
    initial
    begin
        // write strobe idles high so the first strobe gives a clean rising edge
        {o_reset_in_n, o_cs_n, o_dc_sel, o_wr_n, o_protocol_sel_1, o_protocol_sel_0} = 6'h1E;
        o_host_data_bus = 8'h00;
    end

    // every pin phase spans four clocks, above the three the port needs
    task ph();
        repeat (4) @(posedge i_ref_clk);
    endtask

    task boot(input logic [1:0] p);
        @(posedge i_ref_clk);
        o_reset_in_n <= 1'b0;
        {o_protocol_sel_1, o_protocol_sel_0} <= p;
        ph();
        o_reset_in_n <= 1'b1;
    endtask

    // select and byte held around strobe
    task par_wr(input logic cs, input logic dc, input logic [7:0] b);
        @(posedge i_ref_clk);
        o_cs_n <= ~cs;
        o_dc_sel <= dc;
        o_host_data_bus <= b;
        o_wr_n <= 1'b0;
        ph();
        o_wr_n <= 1'b1;
        ph();
        o_cs_n <= 1'b1;
        o_host_data_bus <= ~b;
    endtask

    // clock on line zero, data on one, select grounded in three wire
    task ser_wr(input logic three, input logic dc, input logic [8:0] w, input int n);
        @(posedge i_ref_clk);
        o_cs_n <= 1'b0;
        o_dc_sel <= dc & ~three;
        for (int i = n - 1; i >= 0; i--)
        begin
            o_host_data_bus <= {6'h00, w[i], 1'b0};
            ph();
            o_host_data_bus[0] <= 1'b1;
            ph();
        end
        o_host_data_bus <= {6'h00, ~w[0], 1'b0};
        ph();
        o_cs_n <= 1'b1;
    endtask
endmodule // ohp_host_model

`default_nettype wire

// file: tb/ohp_host_port_tb.sv
`timescale 1ns/100ps
`default_nettype none

module ohp_host_port_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic rdy = 1'b0;
    logic rst_n, cs_n, dc, wr_n, ps0, ps1, oe, frm, init, busy, ovr, bval, bdat;
    logic [7:0] hbus;
    logic [7:0] bd;
    logic [7:0] rbus;
    int n_fail = 0;
    int tests_run = 0;
    int n_ovr = 0;
    logic [8:0] rows [6] = '{9'h1A5, 9'h03C, 9'h100, 9'h0FF, 9'h15A, 9'h000};

    always #25 clk = ~clk;
    always @(negedge clk) if (ovr === 1'b1) n_ovr++;

    ohp_host_model host_i (.i_ref_clk(clk), .o_reset_in_n(rst_n), .o_cs_n(cs_n),
        .o_dc_sel(dc), .o_wr_n(wr_n), .o_protocol_sel_0(ps0), .o_protocol_sel_1(ps1),
        .o_host_data_bus(hbus));

    ohp_host_port #(.FRAME_HALF_CYCLES(8)) ohp_host_port_i (.i_ref_clk(clk),
        .i_srst(srst), .i_reset_in_n(rst_n), .i_cs_n(cs_n), .i_dc_sel(dc),
        .i_wr_n(wr_n), .i_protocol_sel_0(ps0), .i_protocol_sel_1(ps1),
        .i_host_data_bus(hbus), .o_host_data_bus(rbus), .o_host_data_bus_oe(oe),
        .o_frame_status_out(frm), .o_init_active(init), .o_host_busy(busy),
        .o_overrun(ovr), .o_byte_valid(bval), .i_byte_ready(rdy),
        .o_byte_data(bd), .o_byte_is_data(bdat));

    // ==========================================
    // helpers
    task chk(input logic [8:0] seen, input logic [8:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task get_byte(input logic [8:0] e);
        int k;
        k = 0;
        // never look in the time step of the edge that pops the next word
        @(negedge clk);
        while (bval !== 1'b1 && k < 40)
        begin
            @(negedge clk);
            k++;
        end
        chk({8'h00, bval}, 9'h001);
        chk({bdat, bd}, e);
        @(posedge clk) rdy <= 1'b1;
        @(posedge clk) rdy <= 1'b0;
    endtask

    task wait_run();
        int k;
        k = 0;
        while (init !== 1'b0 && k < 100)
        begin
            @(negedge clk);
            k++;
        end
        chk({8'h00, init}, 9'h000);
    endtask

    task tally_and_finish();
        $display("mismatches %0d of %0d checks", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==========================================
    // sequence
    initial
    begin
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk({4'h0, init, busy, bval, frm, oe}, 9'h010);
        @(posedge clk) srst <= 1'b0;
        host_i.boot(2'h2);
        host_i.par_wr(1'b1, 1'b1, 8'h55);
        wait_run();
        chk({8'h00, bval}, 9'h000);
        foreach (rows[i])
        begin
            host_i.par_wr(1'b1, rows[i][8], rows[i][7:0]);
            get_byte(rows[i]);
        end
        chk({oe, rbus}, 9'h000);
        host_i.par_wr(1'b0, 1'b1, 8'hC3);
        repeat (10) @(negedge clk);
        chk({8'h00, bval}, 9'h000);
        // fill 16 words, output stage and slot, then one more is lost
        for (int i = 0; i < 19; i++)
            host_i.par_wr(1'b1, 1'b1, 8'(i));
        repeat (6) @(negedge clk);
        chk({8'h00, busy}, 9'h001);
        chk(9'(n_ovr), 9'h001);
        for (int i = 0; i < 18; i++)
            get_byte({1'b1, 8'(i)});
        host_i.par_wr(1'b1, 1'b1, 8'h11);
        host_i.boot(2'h0);
        wait_run();
        chk({8'h00, bval}, 9'h000);
        host_i.ser_wr(1'b0, 1'b0, 9'h1FF, 4);
        host_i.ser_wr(1'b0, 1'b0, 9'h0A5, 8);
        get_byte(9'h0A5);
        host_i.ser_wr(1'b0, 1'b1, 9'h03C, 8);
        get_byte(9'h13C);
        host_i.boot(2'h1);
        wait_run();
        host_i.ser_wr(1'b1, 1'b1, 9'h181, 9);
        get_byte(9'h181);
        host_i.ser_wr(1'b1, 1'b1, 9'h07E, 9);
        get_byte(9'h07E);
        host_i.boot(2'h3);
        wait_run();
        host_i.par_wr(1'b1, 1'b0, 8'h99);
        get_byte(9'h099);
        tally_and_finish();
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end
endmodule // ohp_host_port_tb

`default_nettype wire
